// >>> slbl_defines.svh
// Constants of the serial boot loader and byte programmer.
// Assumes a 20 MHz system clock and a host that keeps its side of the protocol.
//
// Notes on behaviour
// - Sync byte locks the link at 1200 baud.
// - Every loader byte received is echoed back.
// - Full loader received, execution jumps unprompted.
// - Port C bit 0 low, pointers set, jump.
// - Write 0x04 to 0x1028: wired-OR off.
// - Control registers sit at base 0x1000.
// - Receiver holds one byte while shifting next.
// - Programmed byte is read back and sent.
// - Next buffered byte programs while host verifies.
// - Program, read back, verify repeats until data ends.
`ifndef SLBL_DEFINES_SVH
`define SLBL_DEFINES_SVH

`define SLBL_CLK_HZ 20000000
`define SLBL_BAUD 1200
`define SLBL_BIT_CYC (`SLBL_CLK_HZ / `SLBL_BAUD)
`define SLBL_PROG_US 2000
`define SLBL_PROG_CYC (`SLBL_PROG_US * (`SLBL_CLK_HZ / 1000000))
`define SLBL_SYNC_BYTE 8'hFF
`define SLBL_LOADER_LEN 8'h19
`define SLBL_REG_BASE 16'h1000
`define SLBL_REG_MASK 16'hFFC0
`define SLBL_CFG_OFF 16'h0028
`define SLBL_CFG_VAL 8'h04
`define SLBL_CFG_RST 8'h20
`define SLBL_WOM_BIT 5
`define SLBL_PORTC0_RST 1'b1
`define SLBL_PROG_START 16'hD000
`define SLBL_MEM_AW 8
`define SLBL_FIFO_WIDTH 8
`define SLBL_FIFO_DEPTH 16

`endif

// >>> slbl_fifo.sv
// Synchronous FIFO between the serial receiver and the byte programmer.
// Assumes one clock; both sides use valid and ready handshakes.
`timescale 1ns/1ps
module slbl_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock, reset and enable
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic ce,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } slbl_fifo_s;

   slbl_fifo_s st_q;
   slbl_fifo_s st_d;
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic push;
   logic pop;

   assign in_ready = (st_q.cnt != (AW+1)'(DEPTH));
   assign out_valid = (st_q.cnt != '0);
   assign out_data = mem[st_q.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      st_d = st_q;
      if (push) begin
         st_d.wp = st_q.wp + AW'(1);
      end
      if (pop) begin
         st_d.rp = st_q.rp + AW'(1);
      end
      if (push && !pop) begin
         st_d.cnt = st_q.cnt + (AW+1)'(1);
      end else if (pop && !push) begin
         st_d.cnt = st_q.cnt - (AW+1)'(1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         st_q <= '0;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   // The array holds no reset; stale words are never visible because count gates them.
   always_ff @(posedge clk_sys) begin
      if (ce && push) begin
         mem[st_q.wp] <= in_data;
      end
   end

endmodule

// >>> slbl_host.sv
// Behavioural host that sits on the far side of the serial link.
// Assumes 8N1 framing at BIT_CYC clocks per bit on both lines, and a tb that calls send_byte.
`timescale 1ns/1ps
module slbl_host #(
   parameter int BIT_CYC = 16
) (
   // Clock
   input wire logic clk_sys,
   // Serial link
   output logic rxd,
   input wire logic txd
);
   logic [7:0] rx_q[$];
   logic [7:0] rx_b;

   initial begin
      rxd = 1'b1;
   end

   // Frames change only at falling edges, so the design never samples a moving line.
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      @(negedge clk_sys);
      for (int i = 0; i < 10; i++) begin
         rxd = f[i];
         repeat (BIT_CYC) @(negedge clk_sys);
      end
   endtask

   // Bytes with a bad stop bit are not queued, so a framing slip shows as a missing byte.
   always begin
      @(negedge txd);
      repeat (BIT_CYC / 2) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(posedge clk_sys);
         rx_b[i] = txd;
      end
      repeat (BIT_CYC) @(posedge clk_sys);
      if (txd === 1'b1) begin
         rx_q.push_back(rx_b);
      end
   end
endmodule

// >>> slbl_loader.sv
// Boot loader and byte programmer behind a 1200 baud serial port.
// Assumes rxd comes from a pin and that the host paces data as the protocol requires.
`timescale 1ns/1ps
`include "slbl_defines.svh"
module slbl_loader import slbl_pkg::*; #(
   parameter logic [15:0] BIT_CYC = 16'(`SLBL_BIT_CYC),
   parameter logic [15:0] PROG_CYC = 16'(`SLBL_PROG_CYC)
) (
   // Clock, reset and enable
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic ce,
   // Serial link
   input wire logic rxd,
   output logic txd,
   // Device state
   output logic port_c0,
   output logic wired_or_output_select,
   output logic loaded_setup_code,
   output logic rx_overrun,
   output logic [15:0] prog_addr
);

   typedef struct packed {
      logic rx_meta;
      logic rx_sync;
      logic rx_busy;
      logic [15:0] rx_cnt;
      logic [3:0] rx_bit;
      logic [7:0] rx_sh;
      logic rx_full;
      logic [7:0] rx_hold;
      logic overrun;
      logic tx_busy;
      logic [15:0] tx_cnt;
      logic [3:0] tx_bit;
      logic [9:0] tx_sh;
      logic txd;
      logic tx_req;
      logic [7:0] tx_byte;
      slbl_phase_e phase;
      logic [7:0] load_cnt;
      logic running;
      logic [7:0] cfg;
      logic port_c0;
      logic [15:0] prog_ptr;
      logic [15:0] vfy_ptr;
      slbl_prog_e pstate;
      logic [15:0] pcnt;
      logic [7:0] pdata;
   } slbl_state_s;

   slbl_state_s q;
   slbl_state_s d;
   logic [7:0] mem [0:(1<<`SLBL_MEM_AW)-1];
   logic rx_done;
   logic mem_we;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [7:0] fifo_out_data;
   logic [7:0] rd_data;

   function automatic logic slbl_tick(input logic [15:0] cnt);
      slbl_tick = (cnt == 16'h0000);
   endfunction

   function automatic logic slbl_cfg_hit(input logic [15:0] addr);
      slbl_cfg_hit = ((addr & `SLBL_REG_MASK) == `SLBL_REG_BASE) && ((addr - `SLBL_REG_BASE) == `SLBL_CFG_OFF);
   endfunction

   assign fifo_out_ready = (q.phase == PH_PROG) && (q.pstate == P_IDLE);
   assign rd_data = mem[q.vfy_ptr[`SLBL_MEM_AW-1:0]];

   always_comb begin
      d = q;
      rx_done = 1'b0;
      mem_we = 1'b0;
      d.rx_meta = rxd;
      d.rx_sync = q.rx_meta;
      // Receiver samples mid-bit; a start bit that is gone at mid-bit is treated as a glitch.
      if (!q.rx_busy) begin
         if (!q.rx_sync) begin
            d.rx_busy = 1'b1;
            d.rx_cnt = BIT_CYC >> 1;
            d.rx_bit = 4'h0;
         end
      end else if (!slbl_tick(q.rx_cnt)) begin
         d.rx_cnt = q.rx_cnt - 16'h0001;
      end else begin
         d.rx_cnt = BIT_CYC - 16'h0001;
         d.rx_bit = q.rx_bit + 4'h1;
         if (q.rx_bit == 4'h0) begin
            d.rx_busy = ~q.rx_sync;
         end else if (q.rx_bit == 4'h9) begin
            d.rx_busy = 1'b0;
            rx_done = q.rx_sync;
         end else begin
            d.rx_sh = {q.rx_sync, q.rx_sh[7:1]};
         end
      end
      // Transmitter.
      if (!q.tx_busy) begin
         if (q.tx_req) begin
            d.tx_busy = 1'b1;
            d.tx_req = 1'b0;
            d.tx_sh = {1'b1, q.tx_byte, 1'b0};
            d.tx_bit = 4'h0;
            d.tx_cnt = 16'h0000;
         end
      end else if (!slbl_tick(q.tx_cnt)) begin
         d.tx_cnt = q.tx_cnt - 16'h0001;
      end else if (q.tx_bit == 4'hA) begin
         d.tx_busy = 1'b0;
      end else begin
         d.txd = q.tx_sh[0];
         d.tx_sh = {1'b1, q.tx_sh[9:1]};
         d.tx_bit = q.tx_bit + 4'h1;
         d.tx_cnt = BIT_CYC - 16'h0001;
      end
      // One finished byte waits in the holding register while the next shifts in.
      if (q.rx_full && fifo_in_ready) begin
         d.rx_full = 1'b0;
      end
      case (q.phase)
         PH_SYNC: begin
            if (rx_done && (q.rx_sh == `SLBL_SYNC_BYTE)) begin
               d.phase = PH_LOAD;
               d.load_cnt = 8'h00;
            end
         end
         PH_LOAD: begin
            if (rx_done) begin
               d.tx_req = 1'b1;
               d.tx_byte = q.rx_sh;
               d.load_cnt = q.load_cnt + 8'h01;
               if (q.load_cnt == `SLBL_LOADER_LEN - 8'h01) begin
                  d.phase = PH_SETUP_A;
                  d.running = 1'b1;
               end
            end
         end
         PH_SETUP_A: begin
            // Full address decode; a short page-zero access would miss the relocated block.
            if (slbl_cfg_hit(`SLBL_REG_BASE + `SLBL_CFG_OFF)) begin
               d.cfg = `SLBL_CFG_VAL;
            end
            d.phase = PH_SETUP_B;
         end
         PH_SETUP_B: begin
            d.port_c0 = 1'b0;
            d.prog_ptr = `SLBL_PROG_START;
            d.vfy_ptr = `SLBL_PROG_START;
            d.phase = PH_PROG;
         end
         PH_PROG: begin
            if (rx_done) begin
               if (d.rx_full) begin
                  d.overrun = 1'b1;
               end else begin
                  d.rx_full = 1'b1;
                  d.rx_hold = q.rx_sh;
               end
            end
            case (q.pstate)
               P_IDLE: begin
                  if (fifo_out_valid) begin
                     d.pdata = fifo_out_data;
                     d.pcnt = PROG_CYC - 16'h0001;
                     d.pstate = P_WRITE;
                  end
               end
               P_WRITE: begin
                  if (!slbl_tick(q.pcnt)) begin
                     d.pcnt = q.pcnt - 16'h0001;
                  end else begin
                     mem_we = 1'b1;
                     d.pstate = P_READ;
                  end
               end
               P_READ: begin
                  // A read-back still waiting for the transmitter holds the programmer here.
                  if (!d.tx_req) begin
                     d.tx_req = 1'b1;
                     d.tx_byte = rd_data;
                     d.prog_ptr = q.prog_ptr + 16'h0001;
                     d.vfy_ptr = q.vfy_ptr + 16'h0001;
                     d.pstate = P_IDLE;
                  end
               end
               default: begin
                  d.pstate = P_IDLE;
               end
            endcase
         end
         default: begin
            d.phase = PH_SYNC;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         q <= '0;
         q.rx_meta <= 1'b1;
         q.rx_sync <= 1'b1;
         q.txd <= 1'b1;
         q.cfg <= `SLBL_CFG_RST;
         q.port_c0 <= `SLBL_PORTC0_RST;
      end else if (ce) begin
         q <= d;
      end
   end

   // Memory is not reset; each location is written before it is read back.
   always_ff @(posedge clk_sys) begin
      if (ce && mem_we) begin
         mem[q.prog_ptr[`SLBL_MEM_AW-1:0]] <= q.pdata;
      end
   end

   slbl_fifo #(
      .WIDTH(`SLBL_FIFO_WIDTH),
      .DEPTH(`SLBL_FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .ce(ce),
      .in_valid(q.rx_full),
      .in_ready(fifo_in_ready),
      .in_data(q.rx_hold),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   assign txd = q.txd;
   assign port_c0 = q.port_c0;
   assign wired_or_output_select = q.cfg[`SLBL_WOM_BIT];
   assign loaded_setup_code = q.running;
   assign rx_overrun = q.overrun;
   assign prog_addr = q.prog_ptr;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b || !ce);

   sequence s_setup_a;
      q.phase == PH_SETUP_A;
   endsequence
   sequence s_setup_b;
      (q.phase == PH_SETUP_B) && (q.cfg == `SLBL_CFG_VAL);
   endsequence
   sequence s_prog_entry;
      (q.phase == PH_PROG) && !q.port_c0 && (q.prog_ptr == `SLBL_PROG_START);
   endsequence

   chk_sync_ignore: assert property ((q.phase == PH_SYNC) && rx_done && (q.rx_sh != `SLBL_SYNC_BYTE) |=>
      (q.phase == PH_SYNC)) else $error("Non-sync byte left the sync phase.");
   chk_sync_lock: assert property ((q.phase == PH_SYNC) && rx_done && (q.rx_sh == `SLBL_SYNC_BYTE) |=>
      (q.phase == PH_LOAD) && (q.load_cnt == 8'h00)) else $error("Sync byte did not start loading.");
   chk_echo_byte: assert property ((q.phase == PH_LOAD) && rx_done |=>
      q.tx_req && (q.tx_byte == $past(q.rx_sh))) else $error("Loader byte was not echoed.");
   chk_load_jump: assert property ((q.phase == PH_LOAD) && rx_done && (q.load_cnt == `SLBL_LOADER_LEN - 8'h01) |=>
      s_setup_a) else $error("Loader end did not start execution.");
   chk_setup_steps: assert property (s_setup_a |=> s_setup_b ##1 s_prog_entry)
      else $error("Setup sequence went wrong.");
   chk_cfg_held: assert property ((q.phase == PH_PROG) |-> !wired_or_output_select && (q.cfg == `SLBL_CFG_VAL))
      else $error("Wired-OR option not off while programming.");
   chk_hold_overrun: assert property ((q.phase == PH_PROG) && rx_done && q.rx_full && !fifo_in_ready |=>
      q.overrun && (q.rx_hold == $past(q.rx_hold))) else $error("Held byte was overwritten.");
   chk_readback_send: assert property ((q.pstate == P_READ) && !q.tx_req && !(q.tx_busy == 1'b0 && q.tx_req) |=>
      q.tx_req && (q.tx_byte == $past(rd_data)) && (q.pstate == P_IDLE)) else $error("Read-back not sent.");
   chk_addr_step: assert property ((q.pstate == P_READ) && !q.tx_req |=>
      (q.prog_ptr == $past(q.prog_ptr) + 16'h0001)) else $error("Address did not advance by one.");
   chk_overlap_next: assert property ((q.pstate == P_READ) && !q.tx_req && fifo_out_valid |=> ##1
      (q.pstate == P_WRITE) && (q.pcnt == PROG_CYC - 16'h0001)) else $error("Buffered byte did not start.");

endmodule

// >>> slbl_pkg.sv
// Types shared by the serial boot loader modules.
// Assumes the constants header is compiled alongside.
package slbl_pkg;

   typedef enum logic [2:0] {PH_SYNC, PH_LOAD, PH_SETUP_A, PH_SETUP_B, PH_PROG} slbl_phase_e;

   typedef enum logic [1:0] {P_IDLE, P_WRITE, P_READ} slbl_prog_e;

endpackage

// >>> tb.sv
// Self-checking bench for the serial boot loader and byte programmer.
// Assumes the loader, its FIFO and the host model are compiled alongside.
`timescale 1ns/1ps
`include "slbl_defines.svh"
module tb;
   localparam int BITS = 16;
   localparam int NPACED = 12;
   localparam int NDATA = 18;
   logic clk_sys;
   logic rst_b;
   logic ce;
   logic rxd;
   logic txd;
   logic port_c0;
   logic wired_or_output_select;
   logic loaded_setup_code;
   logic rx_overrun;
   logic [15:0] prog_addr;
   int mismatches;
   int check_count;
   int seed;
   logic [7:0] sent_q[$];
   logic [7:0] b;

   slbl_loader #(.BIT_CYC(16'h0010), .PROG_CYC(16'h0014)) dut (
      .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .rxd(rxd), .txd(txd), .port_c0(port_c0),
      .wired_or_output_select(wired_or_output_select), .loaded_setup_code(loaded_setup_code),
      .rx_overrun(rx_overrun), .prog_addr(prog_addr));
   slbl_host #(.BIT_CYC(BITS)) host (.clk_sys(clk_sys), .rxd(rxd), .txd(txd));

   always #25 clk_sys = ~clk_sys;

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Bounded wait for the host to hold at least n returned bytes.
   task automatic wait_rx(input int n);
      int t;
      t = 0;
      while (host.rx_q.size() < n && t < 3000) begin
         @(negedge clk_sys);
         t++;
      end
      if (host.rx_q.size() < n) begin
         check("returned byte count", 16'(host.rx_q.size()), 16'(n));
         wrap_up();
      end
   endtask

   task automatic check_reset();
      check("txd idle", {15'h0000, txd}, 16'h0001);
      check("port c bit 0", {15'h0000, port_c0}, 16'h0001);
      check("wired-or select", {15'h0000, wired_or_output_select}, 16'h0001);
      check("setup done", {15'h0000, loaded_setup_code}, 16'h0000);
      check("overrun", {15'h0000, rx_overrun}, 16'h0000);
      check("address", prog_addr, 16'h0000);
   endtask

   initial begin
      repeat (100000) @(posedge clk_sys);
      mismatches++;
      wrap_up();
   end

   initial begin
      clk_sys = 1'b0;
      rst_b = 1'b0;
      ce = 1'b1;
      mismatches = 0;
      check_count = 0;
      seed = 7847;
      repeat (3) @(negedge clk_sys);
      rst_b = 1'b1;
      @(negedge clk_sys);
      check_reset();
      host.send_byte(8'h55);
      repeat (4 * BITS) @(negedge clk_sys);
      check("echo before sync", 16'(host.rx_q.size()), 16'h0000);
      host.send_byte(`SLBL_SYNC_BYTE);
      for (int i = 0; i < int'(`SLBL_LOADER_LEN); i++) begin
         b = 8'($random(seed));
         sent_q.push_back(b);
         host.send_byte(b);
      end
      wait_rx(int'(`SLBL_LOADER_LEN));
      while (sent_q.size() > 0) begin
         check("echo", {8'h00, host.rx_q.pop_front()}, {8'h00, sent_q.pop_front()});
      end
      check("setup done", {15'h0000, loaded_setup_code}, 16'h0001);
      check("port c bit 0", {15'h0000, port_c0}, 16'h0000);
      check("wired-or select", {15'h0000, wired_or_output_select}, 16'h0000);
      check("start address", prog_addr, `SLBL_PROG_START);
      for (int k = 0; k < NDATA; k++) begin
         sent_q.push_back(8'($random(seed)));
      end
      // Two bytes go out first so one always shifts in while the one before it programs and is read back.
      host.send_byte(sent_q[0]);
      host.send_byte(sent_q[1]);
      for (int k = 0; k < NDATA; k++) begin
         wait_rx(1);
         check("read-back", {8'h00, host.rx_q.pop_front()}, {8'h00, sent_q[k]});
         if (k + 2 < NPACED) begin
            host.send_byte(sent_q[k + 2]);
         end else if (k + 2 == NPACED) begin
            // The tail goes back to back to lean on the receive buffering.
            for (int j = NPACED; j < NDATA; j++) begin
               host.send_byte(sent_q[j]);
            end
         end
      end
      repeat (2 * BITS) @(negedge clk_sys);
      check("end address", prog_addr, `SLBL_PROG_START + 16'(NDATA));
      check("overrun", {15'h0000, rx_overrun}, 16'h0000);
      // A frame sent while the enable is low must leave no trace once it returns.
      ce = 1'b0;
      host.send_byte(8'($random(seed)));
      ce = 1'b1;
      repeat (4 * BITS) @(negedge clk_sys);
      check("frozen address", prog_addr, `SLBL_PROG_START + 16'(NDATA));
      check("frozen read-back", 16'(host.rx_q.size()), 16'h0000);
      rst_b = 1'b0;
      repeat (2) @(negedge clk_sys);
      check_reset();
      rst_b = 1'b1;
      @(negedge clk_sys);
      check_reset();
      // After a mid-run reset the loader must wait for a fresh sync byte.
      host.send_byte(`SLBL_SYNC_BYTE);
      b = 8'($random(seed));
      host.send_byte(b);
      wait_rx(1);
      check("echo after reset", {8'h00, host.rx_q.pop_front()}, {8'h00, b});
      wrap_up();
   end
endmodule
